// file: include/tsic_defines.svh
// register offsets, field positions, vectors and stack sizes of the interrupt controller
`ifndef TSIC_DEFINES_SVH
`define TSIC_DEFINES_SVH
`define TSIC_CTRL_ADDR 8'h0B
`define TSIC_STATUS_ADDR 8'h0C
`define TSIC_MASK_ADDR 8'h0D
`define TSIC_BIT_GIE 0
`define TSIC_BIT_EXT_EN 1
`define TSIC_BIT_T0_EN 2
`define TSIC_BIT_T1_EN 3
`define TSIC_BIT_EXT_F 4
`define TSIC_BIT_T0_F 5
`define TSIC_BIT_T1_F 6
`define TSIC_CTRL_RESET 8'h00
`define TSIC_VEC_EXT 13'h0004
`define TSIC_VEC_T0 13'h0008
`define TSIC_VEC_T1 13'h000C
`define TSIC_STACK_DEPTH 16
`define TSIC_SP_W 5
`define TSIC_EVT_W 4
`endif

// file: include/tsic_pkg.sv
// types shared by the interrupt controller
package tsic_pkg;
  // request from the core sequencer side
  typedef struct packed {
    logic ret_plain;
    logic ret_reenable;
    logic call;
    logic halt_enter;
  } tsic_core_s;
  typedef enum logic [2:0] {
    TSIC_RUN = 3'b001,
    TSIC_HALT = 3'b010,
    TSIC_WAKE = 3'b100
  } tsic_state_e;
endpackage

// file: rtl/tsic_ctrl.sv
// three source interrupt controller with return stack and halt wake-up
// Summary of operation
// - falling edge on external pin sets external request flag, bit 4
// - pending enabled external request calls vector 04H, clears flag and global enable
// - timer 0 overflow sets bit 5; acknowledged at vector 08H, clears flag and enable
// - timer 1 overflow sets bit 6; acknowledged at vector 0CH, clears flag and enable
// - no acknowledge while stack full; request waits for a return
// - with global enable clear, new requests only set flags
// - software re-enabling inside a routine allows nested acknowledge if stack has room
// - acknowledge pushes only the program counter onto the stack
// - interrupt return sets global enable; plain return leaves it alone
// - requests between two phase-two pulses are serviced at the later pulse
// - priority: external first, then timer 0, then timer 1
// - global enable clear masks all sources, flags still recorded
// - flags stay set until acknowledged or cleared by software
// - bits 0 to 3 are enables, global in bit 0; bit 7 reads zero
// - any of the three sources whose flag was clear at halt entry wakes the device from halt
// - return stack holds 16 entries; full when all occupied
// - flag already set at halt entry does not wake for that source
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "tsic_defines.svh"
module tsic_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_irq_n,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic phase_two_pulse,
  input wire tsic_pkg::tsic_core_s core_req,
  input wire logic [12:0] pc_in,
  output logic ack,
  output logic [12:0] ack_vector,
  output logic [12:0] ret_pc,
  output logic ret_valid,
  output logic stack_full,
  output logic halted,
  output logic wake,
  output logic irq
);
  logic ext_sync_r;
  logic [7:0] ctrl_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [2:0] wake_block_r;
  logic [`TSIC_SP_W-1:0] sp_r;
  logic [3:0] wp_r;
  logic [12:0] stack_r [0:`TSIC_STACK_DEPTH-1];
  tsic_pkg::tsic_state_e state_r;
  logic [2:0] evt;
  logic [2:0] en;
  logic [2:0] pend;
  logic [2:0] grant;
  logic ack_now;
  logic ctrl_wr;
  logic push;
  logic pop;
  logic [3:0] evt_ctl;
  logic [7:0] ctrl_nxt;

  // one-hot fixed priority pick
  function automatic logic [2:0] tsic_pick(input logic [2:0] req);
    tsic_pick = 3'h0;
    if (req[0]) begin
      tsic_pick = 3'h1;
    end else if (req[1]) begin
      tsic_pick = 3'h2;
    end else if (req[2]) begin
      tsic_pick = 3'h4;
    end
  endfunction

  // edge detection of the external pin; pin is taken as synchronous
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_sync_r <= 1'b1;
    end else begin
      ext_sync_r <= ext_irq_n;
    end
  end

  assign evt[0] = ext_sync_r & ~ext_irq_n;
  assign evt[1] = timer0_ovf;
  assign evt[2] = timer1_ovf;
  assign ctrl_wr = reg_wr && (reg_addr == `TSIC_CTRL_ADDR);
  assign en = {ctrl_r[`TSIC_BIT_T1_EN], ctrl_r[`TSIC_BIT_T0_EN], ctrl_r[`TSIC_BIT_EXT_EN]};
  assign stack_full = (sp_r == `TSIC_SP_W'(`TSIC_STACK_DEPTH));
  // acknowledge only on the phase pulse, with global enable set and room on the stack
  assign pend = ctrl_r[6:4] & en & {3{ctrl_r[`TSIC_BIT_GIE]}};
  assign grant = tsic_pick(pend);
  assign ack_now = phase_two_pulse && (|pend) && !stack_full && !core_req.call;

  // control register next value; hardware set comes last so it beats both clears
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt = {1'b0, reg_wdata[6:0]};
    end
    if (ack_now) begin
      ctrl_nxt[6:4] = ctrl_nxt[6:4] & ~grant;
      ctrl_nxt[`TSIC_BIT_GIE] = 1'b0;
    end
    if (core_req.ret_reenable) begin
      ctrl_nxt[`TSIC_BIT_GIE] = 1'b1;
    end
    ctrl_nxt[6:4] = ctrl_nxt[6:4] | evt;
  end

  // control register: enables and request flags
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_r <= `TSIC_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // return stack; only program counter values are kept
  assign push = ack_now || core_req.call;
  assign pop = (core_req.ret_plain || core_req.ret_reenable) && (sp_r != '0);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sp_r <= '0;
      wp_r <= 4'h0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 4'h1; // oldest entry overwritten on plain call overflow
        if (!stack_full) begin
          sp_r <= sp_r + `TSIC_SP_W'(1);
        end
      end else if (pop) begin
        wp_r <= wp_r - 4'h1;
        sp_r <= sp_r - `TSIC_SP_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      stack_r[wp_r] <= pc_in;
    end
  end

  // acknowledge outputs and return data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack <= 1'b0;
      ack_vector <= 13'h0000;
      ret_pc <= 13'h0000;
      ret_valid <= 1'b0;
    end else begin
      ack <= ack_now;
      ret_valid <= pop;
      if (ack_now) begin
        ack_vector <= grant[0] ? `TSIC_VEC_EXT : (grant[1] ? `TSIC_VEC_T0 : `TSIC_VEC_T1);
      end
      if (pop) begin
        ret_pc <= stack_r[wp_r - 4'h1];
      end
    end
  end

  // halt and wake; flags already set at halt entry do not wake
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= tsic_pkg::TSIC_RUN;
      wake_block_r <= 3'h0;
    end else begin
      case (state_r)
        tsic_pkg::TSIC_RUN: begin
          if (core_req.halt_enter) begin
            wake_block_r <= ctrl_r[6:4];
            state_r <= tsic_pkg::TSIC_HALT;
          end
        end
        tsic_pkg::TSIC_HALT: begin
          if (|(evt & ~wake_block_r)) begin
            state_r <= tsic_pkg::TSIC_WAKE;
          end
        end
        tsic_pkg::TSIC_WAKE: begin
          state_r <= tsic_pkg::TSIC_RUN;
        end
        default: begin
          state_r <= tsic_pkg::TSIC_RUN;
        end
      endcase
    end
  end
  assign halted = (state_r == tsic_pkg::TSIC_HALT);
  assign wake = (state_r == tsic_pkg::TSIC_WAKE);

  // sticky event status for system interrupt line, write one to clear
  assign evt_ctl = {ack_now, evt};
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_r <= 4'h0;
      mask_r <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == `TSIC_MASK_ADDR) begin
        mask_r <= reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == `TSIC_STATUS_ADDR) begin
        status_r <= (status_r & ~reg_wdata[3:0]) | evt_ctl; // set beats clear
      end else begin
        status_r <= status_r | evt_ctl;
      end
    end
  end
  assign irq = |(status_r & mask_r);

  // read port, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TSIC_CTRL_ADDR: reg_rdata <= {1'b0, ctrl_r[6:0]};
        `TSIC_STATUS_ADDR: reg_rdata <= {4'h0, status_r};
        `TSIC_MASK_ADDR: reg_rdata <= {4'h0, mask_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks
  sequence s_ext_edge;
    ext_sync_r && !ext_irq_n;
  endsequence
  property p_ext_set;
    @(posedge sys_clk) disable iff (reset) s_ext_edge |=> ctrl_r[`TSIC_BIT_EXT_F] || ack;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext flag not set");
  property p_no_ack_full;
    @(posedge sys_clk) disable iff (reset) stack_full |=> !ack;
  endproperty
  a_no_ack_full: assert property (p_no_ack_full) else $error("ack with stack full");
  property p_gie_clear;
    @(posedge sys_clk) disable iff (reset)
      ack_now && !core_req.ret_reenable |=> !ctrl_r[`TSIC_BIT_GIE];
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("global enable kept");
  property p_masked;
    @(posedge sys_clk) disable iff (reset) !ctrl_r[`TSIC_BIT_GIE] |=> !ack;
  endproperty
  a_masked: assert property (p_masked) else $error("ack while masked");
  property p_prio;
    @(posedge sys_clk) disable iff (reset) ack_now && pend[0] |=> ack_vector == `TSIC_VEC_EXT;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
  property p_phase;
    @(posedge sys_clk) disable iff (reset) !phase_two_pulse |=> !ack;
  endproperty
  a_phase: assert property (p_phase) else $error("ack off phase");
  property p_irq_exit_reenable;
    @(posedge sys_clk) disable iff (reset) core_req.ret_reenable |=> ctrl_r[`TSIC_BIT_GIE];
  endproperty
  a_irq_exit_reenable: assert property (p_irq_exit_reenable) else $error("irq_exit_reenable no enable");
  property p_bit7;
    @(posedge sys_clk) disable iff (reset) 1'b1 |-> !ctrl_r[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 set");

  // timer overflows are always recorded, masked or not
  property p_t0_set;
    @(posedge sys_clk) disable iff (reset) timer0_ovf |=> ctrl_r[`TSIC_BIT_T0_F];
  endproperty
  a_t0_set: assert property (p_t0_set) else $error("timer 0 flag not set");
  property p_t1_set;
    @(posedge sys_clk) disable iff (reset) timer1_ovf |=> ctrl_r[`TSIC_BIT_T1_F];
  endproperty
  a_t1_set: assert property (p_t1_set) else $error("timer 1 flag not set");

  // the vector names the winner of the priority pick
  property p_vec_t0;
    @(posedge sys_clk) disable iff (reset)
      ack_now && !pend[0] && pend[1] |=> ack_vector == `TSIC_VEC_T0;
  endproperty
  a_vec_t0: assert property (p_vec_t0) else $error("timer 0 vector wrong");
  property p_vec_t1;
    @(posedge sys_clk) disable iff (reset)
      ack_now && pend == 3'h4 |=> ack_vector == `TSIC_VEC_T1;
  endproperty
  a_vec_t1: assert property (p_vec_t1) else $error("timer 1 vector wrong");

  // a served external request leaves no flag behind unless a new edge came in
  sequence s_ext_served;
    ack_now && pend[0] && !evt[0] && !ctrl_wr;
  endsequence
  property p_ext_clr;
    @(posedge sys_clk) disable iff (reset) s_ext_served |=> !ctrl_r[`TSIC_BIT_EXT_F];
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("ext flag kept after ack");

  // flags only fall by acknowledge or by a register write
  property p_flag_hold;
    @(posedge sys_clk) disable iff (reset)
      !ctrl_wr && !ack_now |=> ($past(ctrl_r[6:4]) & ~ctrl_r[6:4]) == 3'h0;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  // acknowledge pushes the program counter and nothing else
  property p_push_pc;
    @(posedge sys_clk) disable iff (reset)
      ack_now |=> stack_r[wp_r - 4'h1] == $past(pc_in);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pushed value wrong");
  property p_sp_max;
    @(posedge sys_clk) disable iff (reset) 1'b1 |-> sp_r <= 5'h10;
  endproperty
  a_sp_max: assert property (p_sp_max) else $error("stack level beyond 16");

  // a return with no push in the same cycle pops one level and raises ret_valid
  property p_pop;
    @(posedge sys_clk) disable iff (reset)
      pop && !push |=> ret_valid && sp_r == $past(sp_r) - 5'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("return did not pop");

  // a full stack keeps the pending requests until a return frees a level
  sequence s_full_pend;
    stack_full && (|pend) && !ctrl_wr;
  endsequence
  property p_full_wait;
    @(posedge sys_clk) disable iff (reset)
      s_full_pend |=> (ctrl_r[6:4] & $past(pend)) == $past(pend);
  endproperty
  a_full_wait: assert property (p_full_wait) else $error("request lost while full");

  // the plain return leaves the global enable alone
  property p_ret_plain;
    @(posedge sys_clk) disable iff (reset)
      core_req.ret_plain && !core_req.ret_reenable && !ctrl_wr && !ack_now
        |=> ctrl_r[`TSIC_BIT_GIE] == $past(ctrl_r[`TSIC_BIT_GIE]);
  endproperty
  a_ret_plain: assert property (p_ret_plain) else $error("plain return moved enable");

  // with enables set and room on the stack, the phase pulse must be answered
  sequence s_serve;
    phase_two_pulse && (|pend) && !stack_full && !core_req.call;
  endsequence
  property p_serve;
    @(posedge sys_clk) disable iff (reset) s_serve |=> ack;
  endproperty
  a_serve: assert property (p_serve) else $error("enabled request not served");

  // halt entry, and wake-up by a source whose flag was clear at entry
  sequence s_run_halt;
    core_req.halt_enter && !halted && !wake;
  endsequence
  sequence s_halt_evt;
    halted && (|(evt & ~wake_block_r));
  endsequence
  property p_halt;
    @(posedge sys_clk) disable iff (reset) s_run_halt |=> halted;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_wake;
    @(posedge sys_clk) disable iff (reset) s_halt_evt |=> wake ##1 !halted;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on event");

  // a flag already set at halt entry must not wake for its own source
  sequence s_t0_set_at_halt;
    core_req.halt_enter && !halted && !wake && ctrl_r[`TSIC_BIT_T0_F];
  endsequence
  sequence s_t0_only;
    halted && wake_block_r[1] && timer0_ovf && !timer1_ovf && !evt[0];
  endsequence
  property p_no_wake;
    @(posedge sys_clk) disable iff (reset)
      s_t0_set_at_halt ##[1:8] s_t0_only |=> !wake;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woken by an old flag");

  // a control read returns the register with bit 7 forced low
  property p_rd_ctrl;
    @(posedge sys_clk) disable iff (reset)
      reg_rd && reg_addr == `TSIC_CTRL_ADDR |=> reg_rdata == {1'b0, $past(ctrl_r[6:0])};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");
endmodule

// file: bench/tsic_phase_gen.sv
// core sequencer model that issues the phase-two pulses
`timescale 1ns/10ps
module tsic_phase_gen (
  input wire logic sys_clk,
  input wire logic reset,
  output logic phase_two_pulse
);
  logic [1:0] cnt_r;
  // free count; one pulse in four cycles, so a request waits at most three
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  assign phase_two_pulse = (cnt_r == 2'h3);
endmodule

// file: bench/tb.sv
// self-checking bench of the three source interrupt controller
`timescale 1ns/10ps
`include "tsic_defines.svh"
module tb;
  logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, seen;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic ext_irq_n = 1'b1, timer0_ovf = 1'b0, timer1_ovf = 1'b0, phase_two_pulse;
  logic [12:0] pc_in = 13'h0000, ack_vector, ret_pc;
  logic [12:0] vt [3] = '{`TSIC_VEC_EXT, `TSIC_VEC_T0, `TSIC_VEC_T1};
  logic ack, ret_valid, stack_full, halted, wake, irq;
  tsic_pkg::tsic_core_s core_req = '0;
  int bad_count = 0, comparisons = 0, s, na = 0, nw = 0;
  // 20 ns clock
  always #10 sys_clk = ~sys_clk;
  tsic_phase_gen pg (.sys_clk, .reset, .phase_two_pulse);
  tsic_ctrl dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_irq_n, .timer0_ovf, .timer1_ovf, .phase_two_pulse, .core_req, .pc_in, .ack,
    .ack_vector, .ret_pc, .ret_valid, .stack_full, .halted, .wake, .irq);
  // pulses are counted so none is missed while a task is busy
  always @(posedge sys_clk) begin
    if (ack === 1'b1) na++;
    if (wake === 1'b1) nw++;
  end
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({5'h00, reg_rdata}, {5'h00, e});
  endtask
  // m: bit 0 external falling edge, bit 1 timer 0, bit 2 timer 1
  task automatic ev(input logic [2:0] m);
    @(posedge sys_clk);
    ext_irq_n <= ~m[0];
    timer0_ovf <= m[1];
    timer1_ovf <= m[2];
    @(posedge sys_clk);
    ext_irq_n <= 1'b1;
    timer0_ovf <= 1'b0;
    timer1_ovf <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic cq(input tsic_pkg::tsic_core_s c);
    @(posedge sys_clk);
    core_req <= c;
    @(posedge sys_clk);
    core_req <= '0;
    #1;
  endtask
  // bounded watch for ack (b=0) or wake (b=1); a missing one ends the run
  task automatic wt(input int b, input logic want, input logic [12:0] v);
    for (int i = 0; i < 12 && (b ? nw : na) == 0; i++) begin
      @(posedge sys_clk);
    end
    #1;
    seen = (b ? nw : na) != 0;
    chk({12'h000, seen}, {12'h000, want});
    if (want && !seen) begin
      test_done();
    end
    if (want && b == 0) begin
      chk(ack_vector, v);
    end
    na = 0;
    nw = 0;
  endtask
  // directed corners, random sources and return addresses, then status and halt corners
  initial begin
    void'($urandom(69378));
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h0B, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h0B, 8'h8E);
    rd(8'h0B, 8'h0E);
    ev(3'h7);
    wt(0, 1'b0, 13'h0000);
    rd(8'h0B, 8'h7E);
    pc_in <= 13'h0123;
    wr(8'h0B, 8'h7F);
    wt(0, 1'b1, vt[0]);
    rd(8'h0B, 8'h6E);
    wt(0, 1'b0, 13'h0000);
    cq(4'h4);
    chk({12'h000, ret_valid}, 13'h0001);
    chk(ret_pc, 13'h0123);
    wt(0, 1'b1, vt[1]);
    rd(8'h0B, 8'h4E);
    cq(4'h8);
    rd(8'h0B, 8'h4E);
    wr(8'h0B, 8'h4F);
    wt(0, 1'b1, vt[2]);
    rd(8'h0B, 8'h0E);
    for (s = 0; s < 14; s++) begin
      cq(4'h2);
    end
    chk({12'h000, stack_full}, 13'h0000);
    cq(4'h2);
    chk({12'h000, stack_full}, 13'h0001);
    wr(8'h0B, 8'h0F);
    ev(3'h2);
    wt(0, 1'b0, 13'h0000);
    cq(4'h8);
    wt(0, 1'b1, vt[1]);
    cq(4'h8);
    repeat (6) begin
      s = $urandom_range(2);
      pc_in <= 13'($urandom);
      wr(8'h0B, 8'h0F);
      ev(3'h1 << s);
      wt(0, 1'b1, vt[s]);
      cq(4'h4);
      chk(ret_pc, pc_in);
    end
    wr(8'h0B, 8'h00);
    wr(8'h0C, 8'hFF);
    wr(8'h0D, 8'h02);
    ev(3'h4);
    rd(8'h0C, 8'h04);
    chk({12'h000, irq}, 13'h0000);
    ev(3'h2);
    rd(8'h0C, 8'h06);
    chk({12'h000, irq}, 13'h0001);
    wr(8'h0C, 8'h02);
    chk({12'h000, irq}, 13'h0000);
    wr(8'h0B, 8'h00);
    rd(8'h0B, 8'h00);
    ev(3'h2);
    cq(4'h1);
    chk({12'h000, halted}, 13'h0001);
    ev(3'h2);
    wt(1, 1'b0, 13'h0000);
    chk({12'h000, halted}, 13'h0001);
    ev(3'h1);
    wt(1, 1'b1, 13'h0000);
    chk({12'h000, halted}, 13'h0000);
    test_done();
  end
endmodule
